// ===== verilog/mdsh_device.sv
// Purpose: modem end of the serial data and modem-control link
// Assumes: line side and command parser are outside, on the user ports
// Notes:   one received host character is held until host_ready takes it
`timescale 1ns/1ps
`default_nettype none
module mdsh_device
    import mdsh_pkg::*;
#(
    parameter int DIV           = BAUD_DIV,
    parameter int WIDTH         = DATA_BITS,
    parameter int SLAVE_DIV     = SLAVE_IND_DIV,
    parameter int SLAVE_PULSE   = SLAVE_PULSE_CYC
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    // link
    mdsh_if.device                link,
    // local status and settings
    input  wire logic             local_ready,
    input  wire logic             ring_on,
    input  wire logic             wireless_slave,
    input  wire logic             command_mode,
    input  wire logic             connect_req,
    input  wire logic             carrier_up,
    input  wire logic [1:0]       dtr_action_setting,
    input  wire logic [1:0]       async_mode_setting,
    // responses toward host
    input  wire logic             resp_valid,
    input  wire logic [WIDTH-1:0] resp_data,
    output logic                  resp_ready,
    // line data toward host
    input  wire logic             line_valid,
    input  wire logic [WIDTH-1:0] line_data,
    output logic                  line_ready,
    // characters from host
    output logic                  host_valid,
    output logic [WIDTH-1:0]      host_data,
    input  wire logic             host_ready,
    // line control
    output logic                  off_hook,
    output logic                  enter_command,
    output logic                  hangup,
    output logic                  soft_reset
);
    localparam int PW = $clog2(SLAVE_DIV + 1);
    localparam logic [PW-1:0] PER_M1   = PW'(SLAVE_DIV - 1);
    localparam logic [PW-1:0] PULSE_N  = PW'(SLAVE_PULSE);

    mdsh_link_t       st_q, st_d;
    logic [PW-1:0]    pcnt_q, pcnt_d;
    logic             ring_q, ring_d;
    logic             dsr_q, dsr_d;
    logic             cts_q, cts_d;
    logic             dcd_q, dcd_d;
    logic             hook_q, hook_d;
    logic             cmd_q, cmd_d;
    logic             hup_q, hup_d;
    logic             rst_q, rst_d;
    logic             hv_q, hv_d;
    logic [WIDTH-1:0] hd_q, hd_d;
    logic             tx_valid;
    logic [WIDTH-1:0] tx_data;
    logic             tx_ready;
    logic             rx_valid;
    logic [WIDTH-1:0] rx_data;
    logic             dtr_on;
    logic             ring_act;
    logic             send_resp;
    logic             send_line;

    mdsh_uart #(.DIV(DIV), .WIDTH(WIDTH)) u_uart (
        .clk      (clk),
        .resetn   (resetn),
        .tx_valid (tx_valid),
        .tx_data  (tx_data),
        .tx_ready (tx_ready),
        .tx_line  (link.rxd),
        .rx_line  (link.txd),
        .rx_valid (rx_valid),
        .rx_data  (rx_data)
    );

    assign dtr_on   = (link.dtr_n == ACT_LOW_ON);
    assign ring_act = (ring_q == ACT_LOW_ON);

    // rxd source select
    always_comb begin
        send_resp = tx_ready && resp_valid;
        send_line = tx_ready && !resp_valid && line_valid && !command_mode
                    && (link.rts_n == ACT_LOW_ON) && (st_q == MDSH_ONLINE);
        tx_valid  = send_resp || send_line;
        tx_data   = send_resp ? resp_data : line_data;
    end
    assign resp_ready = send_resp;
    assign line_ready = send_line;

    always_comb begin
        st_d   = st_q;
        pcnt_d = pcnt_q;
        hook_d = hook_q;
        cmd_d  = 1'b0;
        hup_d  = 1'b0;
        rst_d  = 1'b0;
        hv_d   = hv_q;
        hd_d   = hd_q;
        // ring indicate
        if (wireless_slave) begin
            pcnt_d = (pcnt_q == '0) ? PER_M1 : pcnt_q - 1'b1;
            ring_d = (pcnt_q < PULSE_N) ? ACT_LOW_ON : ACT_LOW_OFF;
        end else begin
            pcnt_d = '0;
            ring_d = ring_on ? ACT_LOW_ON : ACT_LOW_OFF;
        end
        // connection
        case (st_q)
            MDSH_IDLE: begin
                hook_d = 1'b0;
                if (ring_on) begin
                    st_d = MDSH_RINGING;
                end else if (dtr_on && connect_req && !ring_act) begin
                    st_d   = MDSH_ONLINE;
                    hook_d = 1'b1;
                end
            end
            MDSH_RINGING: begin
                if (!ring_act && !ring_on && dtr_on && connect_req) begin
                    st_d   = MDSH_ONLINE;
                    hook_d = 1'b1;
                end else if (!ring_on && !connect_req) begin
                    st_d = MDSH_IDLE;
                end
            end
            MDSH_ONLINE: begin
                if (!dtr_on && dtr_action_setting != DTR_IGNORE) begin
                    st_d = MDSH_DISCONN;
                    case (dtr_action_setting)
                        DTR_TO_CMD: cmd_d = 1'b1;
                        DTR_HANGUP: hup_d = 1'b1;
                        default:    rst_d = 1'b1;
                    endcase
                end else if (!carrier_up && async_mode_setting == ASYNC_DIRECT) begin
                    st_d = MDSH_DISCONN;
                    hup_d = 1'b1;
                end
            end
            MDSH_DISCONN: begin
                if (dtr_action_setting != DTR_TO_CMD) begin
                    hook_d = 1'b0;
                end
                if (dtr_on) begin
                    st_d = (hook_q && carrier_up) ? MDSH_ONLINE : MDSH_IDLE;
                end
            end
            default: st_d = MDSH_IDLE;
        endcase
        // host characters, held until taken
        if (hv_q && host_ready) begin
            hv_d = 1'b0;
        end
        if (rx_valid && cts_q == ACT_LOW_ON) begin
            hv_d = 1'b1;
            hd_d = rx_data;
        end
        dsr_d = local_ready ? ACT_LOW_ON : ACT_LOW_OFF;
        cts_d = (local_ready && !(hv_q && !host_ready)) ? ACT_LOW_ON : ACT_LOW_OFF;
        dcd_d = (st_d == MDSH_ONLINE && carrier_up) ? ACT_LOW_ON : ACT_LOW_OFF;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q   <= MDSH_IDLE;
            pcnt_q <= '0;
            ring_q <= ACT_LOW_OFF;
            dsr_q  <= ACT_LOW_OFF;
            cts_q  <= ACT_LOW_OFF;
            dcd_q  <= ACT_LOW_OFF;
            hook_q <= 1'b0;
            cmd_q  <= 1'b0;
            hup_q  <= 1'b0;
            rst_q  <= 1'b0;
            hv_q   <= 1'b0;
            hd_q   <= '0;
        end else begin
            st_q   <= st_d;
            pcnt_q <= pcnt_d;
            ring_q <= ring_d;
            dsr_q  <= dsr_d;
            cts_q  <= cts_d;
            dcd_q  <= dcd_d;
            hook_q <= hook_d;
            cmd_q  <= cmd_d;
            hup_q  <= hup_d;
            rst_q  <= rst_d;
            hv_q   <= hv_d;
            hd_q   <= hd_d;
        end
    end

    assign link.ring_n   = ring_q;
    assign link.dsr_n    = dsr_q;
    assign link.cts_n    = cts_q;
    assign link.dcd_n    = dcd_q;
    assign host_valid    = hv_q;
    assign host_data     = hd_q;
    assign off_hook      = hook_q;
    assign enter_command = cmd_q;
    assign hangup        = hup_q;
    assign soft_reset    = rst_q;
endmodule
`default_nettype wire

// ===== verilog/mdsh_pkg.sv
// Purpose: shared constants and types for the modem serial handshake link
// Assumes: one 20 MHz clock on both ends
// Notes:   baud and ring figures are defaults; ends may override by parameter
package mdsh_pkg;
    localparam int          CLK_HZ        = 20_000_000;
    localparam int          BAUD_DEFAULT  = 115_200;
    localparam int          BAUD_DIV      = CLK_HZ / BAUD_DEFAULT;
    localparam int          DATA_BITS     = 8;
    localparam int          SLAVE_IND_HZ  = 1;
    localparam int          SLAVE_IND_DIV = CLK_HZ / SLAVE_IND_HZ;
    localparam int          SLAVE_PULSE_MS = 100;
    localparam int          SLAVE_PULSE_CYC = (CLK_HZ / 1000) * SLAVE_PULSE_MS;
    localparam logic        MARK          = 1'b1;
    localparam logic        SPACE         = 1'b0;
    localparam logic        ACT_LOW_ON    = 1'b0;
    localparam logic        ACT_LOW_OFF   = 1'b1;
    // dtr_action_setting values
    localparam logic [1:0]  DTR_IGNORE    = 2'h0;
    localparam logic [1:0]  DTR_TO_CMD    = 2'h1;
    localparam logic [1:0]  DTR_HANGUP    = 2'h2;
    localparam logic [1:0]  DTR_RESET     = 2'h3;
    // async_mode_setting values
    localparam logic [1:0]  ASYNC_DIRECT  = 2'h0;
    localparam logic [1:0]  ASYNC_SYNC    = 2'h1;

    typedef enum logic [1:0] {
        MDSH_IDLE     = 2'b00,
        MDSH_RINGING  = 2'b01,
        MDSH_ONLINE   = 2'b10,
        MDSH_DISCONN  = 2'b11
    } mdsh_link_t;
endpackage

// ===== verilog/mdsh_if.sv
// Purpose: pin bundle between modem device and host terminal
// Assumes: all signals synchronous to the shared clock
// Notes:   active-low control lines end in _n
`timescale 1ns/1ps
`default_nettype none
interface mdsh_if;
    logic rxd;
    logic txd;
    logic ring_n;
    logic dsr_n;
    logic cts_n;
    logic dcd_n;
    logic dtr_n;
    logic rts_n;

    modport device (
        output rxd, ring_n, dsr_n, cts_n, dcd_n,
        input  txd, dtr_n, rts_n
    );
    modport host (
        input  rxd, ring_n, dsr_n, cts_n, dcd_n,
        output txd, dtr_n, rts_n
    );
endinterface
`default_nettype wire

// ===== verilog/mdsh_uart.sv
// Purpose: async character transmitter and receiver pair
// Assumes: rx input already synchronous; one start, data lsb first, one stop
// Notes:   tx_ready low while a character is in flight
`timescale 1ns/1ps
`default_nettype none
module mdsh_uart
    import mdsh_pkg::*;
#(
    parameter int DIV   = BAUD_DIV,
    parameter int WIDTH = DATA_BITS
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    // transmit side
    input  wire logic             tx_valid,
    input  wire logic [WIDTH-1:0] tx_data,
    output logic                  tx_ready,
    output logic                  tx_line,
    // receive side
    input  wire logic             rx_line,
    output logic                  rx_valid,
    output logic [WIDTH-1:0]      rx_data
);
    localparam int CW = $clog2(DIV + 1);
    localparam int BW = $clog2(WIDTH + 3);
    localparam logic [CW-1:0] DIV_M1  = CW'(DIV - 1);
    localparam logic [CW-1:0] HALF    = CW'(DIV / 2);
    localparam logic [BW-1:0] TX_LAST = BW'(WIDTH + 1);
    localparam logic [BW-1:0] RX_LAST = BW'(WIDTH);

    logic [WIDTH+1:0] tsh_q, tsh_d;
    logic [BW-1:0]    tbit_q, tbit_d;
    logic [CW-1:0]    tcnt_q, tcnt_d;
    logic             tbusy_q, tbusy_d;
    logic             tline_q, tline_d;
    logic [WIDTH-1:0] rsh_q, rsh_d;
    logic [BW-1:0]    rbit_q, rbit_d;
    logic [CW-1:0]    rcnt_q, rcnt_d;
    logic             rbusy_q, rbusy_d;
    logic             rval_q, rval_d;
    logic [WIDTH-1:0] rdat_q, rdat_d;

    always_comb begin
        tsh_d   = tsh_q;
        tbit_d  = tbit_q;
        tcnt_d  = tcnt_q;
        tbusy_d = tbusy_q;
        tline_d = tline_q;
        if (!tbusy_q) begin
            tline_d = MARK;
            if (tx_valid) begin
                tsh_d   = {MARK, tx_data, SPACE};
                tbusy_d = 1'b1;
                tbit_d  = '0;
                tcnt_d  = DIV_M1;
                tline_d = SPACE;
            end
        end else if (tcnt_q != '0) begin
            tcnt_d = tcnt_q - 1'b1;
        end else if (tbit_q == TX_LAST) begin
            tbusy_d = 1'b0;
            tline_d = MARK;
        end else begin
            tbit_d  = tbit_q + 1'b1;
            tcnt_d  = DIV_M1;
            tline_d = tsh_q[tbit_q + 1'b1];
        end
    end

    always_comb begin
        rsh_d   = rsh_q;
        rbit_d  = rbit_q;
        rcnt_d  = rcnt_q;
        rbusy_d = rbusy_q;
        rval_d  = 1'b0;
        rdat_d  = rdat_q;
        if (!rbusy_q) begin
            if (rx_line == SPACE) begin
                rbusy_d = 1'b1;
                rcnt_d  = HALF;
                rbit_d  = '0;
            end
        end else if (rcnt_q != '0) begin
            rcnt_d = rcnt_q - 1'b1;
        end else begin
            rcnt_d = DIV_M1;
            if (rbit_q == '0 && rx_line != SPACE) begin
                rbusy_d = 1'b0;
            end else if (rbit_q == RX_LAST + 1'b1) begin
                rbusy_d = 1'b0;
                if (rx_line == MARK) begin
                    rval_d = 1'b1;
                    rdat_d = rsh_q;
                end
            end else begin
                if (rbit_q != '0) begin
                    rsh_d = {rx_line, rsh_q[WIDTH-1:1]};
                end
                rbit_d = rbit_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tsh_q   <= '1;
            tbit_q  <= '0;
            tcnt_q  <= '0;
            tbusy_q <= 1'b0;
            tline_q <= MARK;
            rsh_q   <= '0;
            rbit_q  <= '0;
            rcnt_q  <= '0;
            rbusy_q <= 1'b0;
            rval_q  <= 1'b0;
            rdat_q  <= '0;
        end else begin
            tsh_q   <= tsh_d;
            tbit_q  <= tbit_d;
            tcnt_q  <= tcnt_d;
            tbusy_q <= tbusy_d;
            tline_q <= tline_d;
            rsh_q   <= rsh_d;
            rbit_q  <= rbit_d;
            rcnt_q  <= rcnt_d;
            rbusy_q <= rbusy_d;
            rval_q  <= rval_d;
            rdat_q  <= rdat_d;
        end
    end

    assign tx_ready = !tbusy_q;
    assign tx_line  = tline_q;
    assign rx_valid = rval_q;
    assign rx_data  = rdat_q;
endmodule
`default_nettype wire

// ===== verilog/mdsh_host.sv
// Purpose: terminal end of the serial data and modem-control link
// Assumes: user supplies bytes with valid/ready
// Notes:   received bytes are dropped while dsr_n is high
`timescale 1ns/1ps
`default_nettype none
module mdsh_host
    import mdsh_pkg::*;
#(
    parameter int DIV   = BAUD_DIV,
    parameter int WIDTH = DATA_BITS
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    // link
    mdsh_if.host                  link,
    // user control
    input  wire logic             term_ready,
    input  wire logic             can_receive,
    // bytes toward device
    input  wire logic             send_valid,
    input  wire logic [WIDTH-1:0] send_data,
    output logic                  send_ready,
    // bytes from device
    output logic                  recv_valid,
    output logic [WIDTH-1:0]      recv_data,
    // status seen
    output logic                  ring_seen,
    output logic                  dev_ready,
    output logic                  carrier_seen
);
    logic             dtr_q, dtr_d;
    logic             rts_q, rts_d;
    logic             rv_q, rv_d;
    logic [WIDTH-1:0] rd_q, rd_d;
    logic             ring_q, ring_d;
    logic             dev_q, dev_d;
    logic             car_q, car_d;
    logic             tx_ready;
    logic             tx_valid;
    logic             rx_valid;
    logic [WIDTH-1:0] rx_data;
    logic             dev_ok;

    mdsh_uart #(.DIV(DIV), .WIDTH(WIDTH)) u_uart (
        .clk      (clk),
        .resetn   (resetn),
        .tx_valid (tx_valid),
        .tx_data  (send_data),
        .tx_ready (tx_ready),
        .tx_line  (link.txd),
        .rx_line  (link.rxd),
        .rx_valid (rx_valid),
        .rx_data  (rx_data)
    );

    assign dev_ok     = (link.dsr_n == ACT_LOW_ON);
    assign tx_valid   = send_valid && dev_ok && (link.cts_n == ACT_LOW_ON);
    assign send_ready = tx_valid && tx_ready;

    always_comb begin
        dtr_d = term_ready ? ACT_LOW_ON : ACT_LOW_OFF;
        rts_d = can_receive ? ACT_LOW_ON : ACT_LOW_OFF;
        rv_d  = rx_valid && dev_ok;
        rd_d  = rx_valid ? rx_data : rd_q;
        ring_d = (link.ring_n == ACT_LOW_ON);
        dev_d  = dev_ok;
        car_d  = dev_ok && (link.dcd_n == ACT_LOW_ON);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dtr_q  <= ACT_LOW_OFF;
            rts_q  <= ACT_LOW_OFF;
            rv_q   <= 1'b0;
            rd_q   <= '0;
            ring_q <= 1'b0;
            dev_q  <= 1'b0;
            car_q  <= 1'b0;
        end else begin
            dtr_q  <= dtr_d;
            rts_q  <= rts_d;
            rv_q   <= rv_d;
            rd_q   <= rd_d;
            ring_q <= ring_d;
            dev_q  <= dev_d;
            car_q  <= car_d;
        end
    end

    assign link.dtr_n   = dtr_q;
    assign link.rts_n   = rts_q;
    assign recv_valid   = rv_q;
    assign recv_data    = rd_q;
    assign ring_seen    = ring_q;
    assign dev_ready    = dev_q;
    assign carrier_seen = car_q;
endmodule
`default_nettype wire

// ===== verif/mdsh_link_asserts.sv
// Purpose: interface checks for the modem serial handshake link
// Assumes: both ends share one clock; frame is start, 8 data, stop
// Notes:   counters follow each serial line through a frame
`timescale 1ns/1ps
`default_nettype none
module mdsh_link_asserts
    import mdsh_pkg::*;
#(
    parameter int DIV = BAUD_DIV
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // device to host
    input  wire logic rxd,
    input  wire logic ring_n,
    input  wire logic dsr_n,
    input  wire logic cts_n,
    input  wire logic dcd_n,
    // host to device
    input  wire logic txd,
    input  wire logic dtr_n,
    input  wire logic rts_n
);
    localparam int LEN = 10 * DIV;
    logic [15:0] cnt_q [2];
    logic [15:0] cnt_d [2];
    logic [1:0]  line;

    assign line = {txd, rxd};

    // frame position of each line, 0 when idle
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (cnt_q[i] == 16'h0) cnt_d[i] = line[i] ? 16'h0 : 16'h2;
            else if (cnt_q[i] == 16'(LEN)) cnt_d[i] = 16'h0;
            else cnt_d[i] = cnt_q[i] + 16'h1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) cnt_q <= '{default: 16'h0};
        else cnt_q <= cnt_d;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_rxd_start_low: assert property (
        cnt_q[0] >= 16'h2 && cnt_q[0] <= 16'(DIV) |-> !rxd) else $error("rxd start bit high");
    a_rxd_stop_mark: assert property (
        cnt_q[0] > 16'(9 * DIV) |-> rxd) else $error("rxd stop bit low");
    a_rxd_frame_gap: assert property (
        cnt_q[0] == 16'(LEN) |=> rxd) else $error("rxd not at mark after frame");
    a_txd_start_low: assert property (
        cnt_q[1] >= 16'h2 && cnt_q[1] <= 16'(DIV) |-> !txd) else $error("txd start bit high");
    a_txd_stop_mark: assert property (
        cnt_q[1] > 16'(9 * DIV) |-> txd) else $error("txd stop bit low");
    a_txd_needs_cts: assert property (
        cnt_q[1] == 16'h0 && !txd |-> !($past(cts_n) && $past(cts_n, 2) && $past(cts_n, 3)))
        else $error("txd frame started while clear-to-send off");
    a_txd_needs_dsr: assert property (
        cnt_q[1] == 16'h0 && !txd |-> !($past(dsr_n) && $past(dsr_n, 2) && $past(dsr_n, 3)))
        else $error("txd frame started while device not ready");
    a_reset_idle: assert property (
        $rose(resetn) |-> rxd && txd && ring_n && dsr_n && cts_n && dcd_n && dtr_n && rts_n)
        else $error("lines not idle after reset");

    c_rxd_frame: cover property (cnt_q[0] == 16'(LEN));
    c_txd_frame: cover property (cnt_q[1] == 16'(LEN));
    c_ring: cover property ($fell(ring_n));
    c_carrier: cover property ($fell(dcd_n));
endmodule
`default_nettype wire

// ===== verif/modem_dte_serial_handshake_tb.sv
// Purpose: drives both link ends and checks bytes and control lines
// Assumes: shortened baud on both ends, shortened ring counts on the device
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module modem_dte_serial_handshake_tb
    import mdsh_pkg::*;
();
    localparam int DIV  = 8;
    localparam int SDIV = 100;
    localparam int SPUL = 10;
    localparam int PER  = 50;
    logic       clk, resetn, local_ready, ring_on, wireless_slave, command_mode;
    logic       connect_req, carrier_up, resp_valid, resp_ready, line_valid, line_ready;
    logic       host_valid, host_ready, off_hook, enter_command, hangup, soft_reset;
    logic       term_ready, can_receive, send_valid, send_ready, recv_valid;
    logic       ring_seen, dev_ready, carrier_seen, ok, prev, pclr;
    logic [1:0] dtr_action_setting, async_mode_setting;
    logic [7:0] resp_data, line_data, host_data, send_data, recv_data, d1, d2;
    logic [2:0] pulses;
    logic [7:0] rq[$], hq[$], sent[$];
    int         n_errors, check_count, nf;

    mdsh_if link ();
    mdsh_device #(.DIV(DIV), .WIDTH(8), .SLAVE_DIV(SDIV), .SLAVE_PULSE(SPUL)) u_mdsh_device (
        .clk(clk), .resetn(resetn), .link(link), .local_ready(local_ready),
        .ring_on(ring_on), .wireless_slave(wireless_slave), .command_mode(command_mode),
        .connect_req(connect_req), .carrier_up(carrier_up),
        .dtr_action_setting(dtr_action_setting), .async_mode_setting(async_mode_setting),
        .resp_valid(resp_valid), .resp_data(resp_data), .resp_ready(resp_ready),
        .line_valid(line_valid), .line_data(line_data), .line_ready(line_ready),
        .host_valid(host_valid), .host_data(host_data), .host_ready(host_ready),
        .off_hook(off_hook), .enter_command(enter_command), .hangup(hangup),
        .soft_reset(soft_reset));
    mdsh_host #(.DIV(DIV), .WIDTH(8)) u_mdsh_host (
        .clk(clk), .resetn(resetn), .link(link), .term_ready(term_ready),
        .can_receive(can_receive), .send_valid(send_valid), .send_data(send_data),
        .send_ready(send_ready), .recv_valid(recv_valid), .recv_data(recv_data),
        .ring_seen(ring_seen), .dev_ready(dev_ready), .carrier_seen(carrier_seen));
    mdsh_link_asserts #(.DIV(DIV)) u_mdsh_link_asserts (
        .clk(clk), .resetn(resetn), .rxd(link.rxd), .ring_n(link.ring_n),
        .dsr_n(link.dsr_n), .cts_n(link.cts_n), .dcd_n(link.dcd_n), .txd(link.txd),
        .dtr_n(link.dtr_n), .rts_n(link.rts_n));

    initial begin
        clk = 1'b0;
        forever #(PER / 2) clk = ~clk;
    end

    // collect bytes and line-control pulses; device side stalls at random
    always @(posedge clk) begin
        if (recv_valid === 1'b1) rq.push_back(recv_data);
        if (host_valid === 1'b1 && host_ready === 1'b1) hq.push_back(host_data);
        pulses <= pclr ? 3'h0 : (pulses | {soft_reset, hangup, enter_command});
        host_ready <= #1 ($urandom_range(3) != 0);
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // src 0 response, 1 line data, 2 host byte; valid held until taken or lim cycles pass
    task automatic push(input int src, input logic [7:0] d, input int lim, output logic tk);
        tk = 1'b0;
        if (src == 0) {resp_valid, resp_data} = {1'b1, d};
        else if (src == 1) {line_valid, line_data} = {1'b1, d};
        else {send_valid, send_data} = {1'b1, d};
        for (int i = 0; i < lim && tk !== 1'b1; i++) begin
            #1 tk = (src == 0) ? resp_ready : (src == 1) ? line_ready : send_ready;
            tick(1);
        end
        if (src == 0) resp_valid = 1'b0;
        else if (src == 1) line_valid = 1'b0;
        else send_valid = 1'b0;
        tick(1);
    endtask

    task automatic expect_rx(input logic [7:0] d);
        for (int i = 0; i < 400 && rq.size() == 0; i++) tick(1);
        chk(rq.size() != 0, 1'b1);
        if (rq.size() != 0) chk(rq.pop_front(), d);
    endtask

    task automatic go_online();
        {term_ready, connect_req, carrier_up, ring_on} = 4'hE;
        for (int i = 0; i < 60 && link.dcd_n !== 1'b0; i++) tick(1);
        chk(link.dtr_n, ACT_LOW_ON);
        chk(off_hook, 1'b1);
        chk(link.dcd_n, ACT_LOW_ON);
    endtask

    function automatic logic [2:0] dtr_exp(input logic [1:0] s);
        case (s)
            DTR_TO_CMD: return 3'h1;
            DTR_HANGUP: return 3'h2;
            DTR_RESET:  return 3'h4;
            default:    return 3'h0;
        endcase
    endfunction

    initial begin
        #(PER * 30000);
        n_errors++;
        end_sim();
    end

    initial begin
        resetn = 1'b0;
        {resp_valid, line_valid, send_valid, ring_on, wireless_slave} = 5'h0;
        {command_mode, connect_req, carrier_up, term_ready} = 4'h0;
        {local_ready, can_receive, pclr} = 3'h7;
        {resp_data, line_data, send_data} = 24'h0;
        dtr_action_setting = DTR_IGNORE;
        async_mode_setting = ASYNC_DIRECT;
        n_errors = 0;
        check_count = 0;
        void'($urandom(37151));
        repeat (4) @(posedge clk);
        #1 resetn = 1'b1;
        pclr = 1'b0;
        tick(2);
        chk(link.dsr_n, ACT_LOW_ON);
        chk(dev_ready, 1'b1);
        ring_on = 1'b1;
        tick(4);
        chk(link.ring_n, ACT_LOW_ON);
        chk(ring_seen, 1'b1);
        {term_ready, connect_req, carrier_up} = 3'h7;
        tick(40);
        chk(off_hook, 1'b0);
        go_online();
        chk(link.ring_n, ACT_LOW_OFF);
        d1 = 8'($urandom);
        d2 = 8'($urandom);
        {line_valid, line_data} = {1'b1, d1};
        push(0, d2, 400, ok);
        push(1, d1, 400, ok);
        expect_rx(d2);
        expect_rx(d1);
        command_mode = 1'b1;
        push(1, d1, 200, ok);
        chk(ok, 1'b0);
        can_receive = 1'b0;
        push(0, d2, 400, ok);
        expect_rx(d2);
        command_mode = 1'b0;
        push(1, d1, 200, ok);
        chk(ok, 1'b0);
        can_receive = 1'b1;
        push(1, d1, 400, ok);
        expect_rx(d1);
        sent = {8'h00, 8'hFF, 8'h01, 8'h80};
        repeat (4) sent.push_back(8'($urandom));
        foreach (sent[i]) begin
            push(2, sent[i], 400, ok);
            chk(ok, 1'b1);
        end
        tick(200);
        chk(8'(hq.size()), 8'h08);
        while (sent.size() != 0 && hq.size() != 0) chk(hq.pop_front(), sent.pop_front());
        local_ready = 1'b0;
        tick(4);
        chk(link.dsr_n, ACT_LOW_OFF);
        chk(link.cts_n, ACT_LOW_OFF);
        push(2, 8'h5A, 100, ok);
        chk(ok, 1'b0);
        local_ready = 1'b1;
        tick(4);
        pclr = 1'b1;
        tick(1);
        pclr = 1'b0;
        carrier_up = 1'b0;
        tick(20);
        chk(pulses[1], 1'b1);
        chk(link.dcd_n, ACT_LOW_OFF);
        chk(carrier_seen, 1'b0);
        chk(link.dsr_n, ACT_LOW_ON);
        for (int s = 0; s < 4; s++) begin
            dtr_action_setting = 2'(s);
            go_online();
            pclr = 1'b1;
            tick(1);
            pclr = 1'b0;
            term_ready = 1'b0;
            tick(20);
            chk(link.dtr_n, ACT_LOW_OFF);
            chk(pulses, dtr_exp(2'(s)));
            if (s == 0) chk(link.dcd_n, ACT_LOW_ON);
            if (s == 0) begin
                chk(carrier_seen, 1'b1);
                async_mode_setting = ASYNC_SYNC;
                carrier_up = 1'b0;
                tick(20);
                chk(pulses, 3'h0);
                chk(link.dcd_n, ACT_LOW_OFF);
                async_mode_setting = ASYNC_DIRECT;
            end
        end
        {term_ready, connect_req, wireless_slave} = 3'h1;
        tick(5);
        nf = 0;
        for (int i = 0; i < 3 * SDIV; i++) begin
            prev = link.ring_n;
            tick(1);
            if (prev === 1'b1 && link.ring_n === 1'b0) nf++;
        end
        chk(8'(nf), 8'h03);
        wireless_slave = 1'b0;
        tick(20);
        chk(link.rxd, MARK);
        chk(link.txd, MARK);
        end_sim();
    end
endmodule
`default_nettype wire
